// file: inc/asp_pkg.sv
package asp_pkg;

    // ----------------------------------------
    // memory geometry
    // ----------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 8;
    localparam int DEPTH = 524288;

    // ----------------------------------------
    // clock and counter
    // ----------------------------------------
    localparam int CLK_PERIOD_PS = 10000;
    localparam int CNT_W = 5;

    // ----------------------------------------
    // pin timing in ns, index 0..2 = high, middle, low supply range
    // ----------------------------------------
    localparam int ADDRESS_ACCESS_DELAY_NS [0:2] = '{70, 85, 150};
    localparam int OUTPUT_HOLD_AFTER_ADDRESS_NS [0:2] = '{10, 10, 10};
    localparam int ADDRESS_SETUP_TO_WRITE_END_NS [0:2] = '{60, 75, 100};
    localparam int DATA_SETUP_TO_WRITE_END_NS [0:2] = '{30, 50, 80};
    localparam int WRITE_PULSE_WIDTH_NS [0:2] = '{50, 65, 100};
    localparam int WRITE_TO_FLOAT_DELAY_NS [0:2] = '{25, 35, 70};
    localparam int OUTPUT_OFF_TO_FLOAT_DELAY_NS [0:2] = '{25, 35, 50};
    localparam int DESELECT_TO_FLOAT_DELAY_NS [0:2] = '{25, 35, 50};
    localparam int ADDRESS_HOLD_AFTER_WRITE_NS = 0;
    localparam int ADDRESS_SETUP_TO_WRITE_START_NS = 0;

    // ----------------------------------------
    // controller states
    // ----------------------------------------
    typedef enum logic [2:0]
    {
        ASP_IDLE = 3'h0,
        ASP_RD = 3'h1,
        ASP_GAP = 3'h3,
        ASP_ARM = 3'h4,
        ASP_WR = 3'h6,
        ASP_HOLD = 3'h7
    } asp_state_t;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed
    {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asp_req_t;

    typedef struct packed
    {
        logic sel_n;
        logic wr_n;
        logic out_n;
        logic [ADDR_W-1:0] addr;
    } asp_pins_t;

    localparam asp_pins_t PINS_RESET = '{sel_n: 1'b1, wr_n: 1'b1, out_n: 1'b1, addr: '0};

    // least time rounds up to whole cycles, never below one
    function automatic int cycles_up(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction : cycles_up

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

endpackage : asp_pkg

// file: rtl/asp_interval.sv
`timescale 1ns/100ps

module asp_interval #(
    parameter int W = 5
) (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic load, // start a new interval
    input wire logic [W-1:0] load_val, // cycles minus one
    output logic [W-1:0] count, // cycles still to run
    output logic expired // interval over
);

    logic [W-1:0] count_reg;

    // ----------------------------------------
    // down counter, parks at zero
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            count_reg <= '0;
        else if (load)
            count_reg <= load_val;
        else if (count_reg != '0)
            count_reg <= count_reg - 1'b1;
    end

    assign count = count_reg;
    assign expired = (count_reg == '0);

endmodule : asp_interval

// file: rtl/asp_sram_host.sv
`timescale 1ns/100ps

// Summary of operation
// - write happens while select and write strobe are both low.
// - read needs select and output strobe low, write strobe high.
// - write ends at first rise of select or write strobe.
// - data setup and hold count from the edge ending the write.
// - write with output strobe low lasts float delay plus data setup.
// - address stable 60, 75 or 100 ns before write ends.
// - write data valid 30, 50 or 80 ns before write ends.
// - address must not change before write ends; zero hold after.
// - address stable when write starts; zero setup before.
// - select-timed read needs address valid by select falling.
// - host must not drive data while device drives it.

module asp_sram_host #(
    parameter int SPEED_GRADE = 0, // 0 high, 1 middle, 2 low supply range
    parameter bit WRITE_END_BY_SELECT = 1'b0, // select ends writes
    parameter bit OUT_LOW_WRITES = 1'b0 // output strobe stays low in writes
) (
    input wire logic clk, // system clock, 100 MHz
    input wire logic resetn, // async reset, active low
    input wire logic req_valid, // request offered
    input wire asp_pkg::asp_req_t req, // request contents
    output logic req_ready, // request can be taken
    output logic rsp_valid, // read data pulse
    output logic [asp_pkg::DATA_W-1:0] rsp_rdata, // read data
    output logic wr_done, // write finished pulse
    output logic standby, // memory deselected
    output asp_pkg::asp_pins_t pins, // address and strobes
    output logic [asp_pkg::DATA_W-1:0] mem_wdata, // data to memory
    output logic data_oe_n, // data enable, low drives
    input wire logic [asp_pkg::DATA_W-1:0] mem_rdata // data from memory
);

    // ----------------------------------------
    // cycle counts for the chosen supply range
    // ----------------------------------------
    localparam int ACC_CYC =
        asp_pkg::cycles_up(asp_pkg::ADDRESS_ACCESS_DELAY_NS[SPEED_GRADE]);
    localparam int AW_CYC =
        asp_pkg::cycles_up(asp_pkg::ADDRESS_SETUP_TO_WRITE_END_NS[SPEED_GRADE]);
    localparam int SD_CYC =
        asp_pkg::cycles_up(asp_pkg::DATA_SETUP_TO_WRITE_END_NS[SPEED_GRADE]);
    localparam int PWE_CYC =
        asp_pkg::cycles_up(asp_pkg::WRITE_PULSE_WIDTH_NS[SPEED_GRADE]);
    localparam int HZWE_CYC =
        asp_pkg::cycles_up(asp_pkg::WRITE_TO_FLOAT_DELAY_NS[SPEED_GRADE]);
    localparam int HZOE_CYC =
        asp_pkg::cycles_up(asp_pkg::OUTPUT_OFF_TO_FLOAT_DELAY_NS[SPEED_GRADE]);
    localparam int HZCE_CYC =
        asp_pkg::cycles_up(asp_pkg::DESELECT_TO_FLOAT_DELAY_NS[SPEED_GRADE]);
    localparam int GAP_CYC = asp_pkg::max2(HZOE_CYC, HZCE_CYC);
    localparam int WR_BASE = asp_pkg::max2(asp_pkg::max2(AW_CYC, PWE_CYC), SD_CYC);
    localparam int WR_CYC =
        OUT_LOW_WRITES ? asp_pkg::max2(WR_BASE, HZWE_CYC + SD_CYC) : WR_BASE;

    localparam logic [asp_pkg::CNT_W-1:0] ACC_LD = asp_pkg::CNT_W'(ACC_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0] GAP_LD = asp_pkg::CNT_W'(GAP_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0] WR_LD = asp_pkg::CNT_W'(WR_CYC - 1);
    localparam logic [asp_pkg::CNT_W-1:0] SD_LEFT = asp_pkg::CNT_W'(SD_CYC);
    localparam logic [asp_pkg::CNT_W-1:0] ONE_LEFT = asp_pkg::CNT_W'(1);

    // ----------------------------------------
    // state
    // ----------------------------------------
    asp_pkg::asp_state_t st_reg;
    asp_pkg::asp_state_t st_next;
    asp_pkg::asp_pins_t pins_reg;
    asp_pkg::asp_pins_t pins_next;
    asp_pkg::asp_req_t cur_reg;
    asp_pkg::asp_req_t cur_next;
    logic wpend_reg;
    logic wpend_next;
    logic [asp_pkg::DATA_W-1:0] dout_reg;
    logic [asp_pkg::DATA_W-1:0] dout_next;
    logic doe_n_reg;
    logic doe_n_next;
    logic ready_reg;
    logic ready_next;
    logic rsp_valid_reg;
    logic [asp_pkg::DATA_W-1:0] rdata_reg;
    logic wr_done_reg;
    logic standby_reg;

    logic take;
    logic cnt_load;
    logic [asp_pkg::CNT_W-1:0] cnt_val;
    logic [asp_pkg::CNT_W-1:0] cnt;
    logic expired;

    assign take = req_valid && ready_reg;

    // ----------------------------------------
    // interval timer
    // ----------------------------------------
    asp_interval #(
        .W(asp_pkg::CNT_W)
    ) u_interval (
        .clk(clk),
        .resetn(resetn),
        .load(cnt_load),
        .load_val(cnt_val),
        .count(cnt),
        .expired(expired)
    );

    // ----------------------------------------
    // sequencing
    // ----------------------------------------
    always_comb
    begin
        st_next = st_reg;
        pins_next = pins_reg;
        cur_next = cur_reg;
        wpend_next = wpend_reg;
        dout_next = dout_reg;
        doe_n_next = doe_n_reg;
        cnt_load = 1'b0;
        cnt_val = '0;
        unique case (st_reg)
            asp_pkg::ASP_IDLE:
            begin
                if (take && req.write)
                begin
                    // address and first strobe move together: zero setup
                    cur_next = req;
                    pins_next.addr = req.addr;
                    pins_next.sel_n = WRITE_END_BY_SELECT;
                    pins_next.wr_n = !WRITE_END_BY_SELECT;
                    pins_next.out_n = !OUT_LOW_WRITES;
                    dout_next = req.wdata;
                    doe_n_next = OUT_LOW_WRITES;
                    st_next = asp_pkg::ASP_ARM;
                end
                else if (take)
                begin
                    cur_next = req;
                    pins_next.addr = req.addr;
                    pins_next.sel_n = 1'b0;
                    pins_next.out_n = 1'b0;
                    pins_next.wr_n = 1'b1;
                    doe_n_next = 1'b1;
                    cnt_load = 1'b1;
                    cnt_val = ACC_LD;
                    st_next = asp_pkg::ASP_RD;
                end
            end
            asp_pkg::ASP_RD:
            begin
                if (expired && take && !req.write)
                begin
                    // back to back reads keep select low, only address moves
                    cur_next = req;
                    pins_next.addr = req.addr;
                    cnt_load = 1'b1;
                    cnt_val = ACC_LD;
                end
                else if (expired)
                begin
                    // a write must wait until the memory lets go of the bus
                    if (take)
                    begin
                        cur_next = req;
                        wpend_next = 1'b1;
                    end
                    pins_next.sel_n = 1'b1;
                    pins_next.out_n = 1'b1;
                    cnt_load = 1'b1;
                    cnt_val = GAP_LD;
                    st_next = asp_pkg::ASP_GAP;
                end
            end
            asp_pkg::ASP_GAP:
            begin
                if (expired && wpend_reg)
                begin
                    wpend_next = 1'b0;
                    pins_next.addr = cur_reg.addr;
                    pins_next.sel_n = WRITE_END_BY_SELECT;
                    pins_next.wr_n = !WRITE_END_BY_SELECT;
                    pins_next.out_n = !OUT_LOW_WRITES;
                    dout_next = cur_reg.wdata;
                    doe_n_next = OUT_LOW_WRITES;
                    st_next = asp_pkg::ASP_ARM;
                end
                else if (expired)
                begin
                    st_next = asp_pkg::ASP_IDLE;
                end
            end
            asp_pkg::ASP_ARM:
            begin
                // second strobe falls: the write interval opens here
                pins_next.sel_n = 1'b0;
                pins_next.wr_n = 1'b0;
                cnt_load = 1'b1;
                cnt_val = WR_LD;
                st_next = asp_pkg::ASP_WR;
            end
            asp_pkg::ASP_WR:
            begin
                // with output strobe low the memory drives until it floats
                if (OUT_LOW_WRITES && cnt <= SD_LEFT)
                begin
                    doe_n_next = 1'b0;
                end
                if (expired)
                begin
                    pins_next.sel_n = 1'b1;
                    pins_next.wr_n = !WRITE_END_BY_SELECT;
                    st_next = asp_pkg::ASP_HOLD;
                end
            end
            asp_pkg::ASP_HOLD:
            begin
                // data and address held one cycle past the ending edge
                pins_next.sel_n = 1'b1;
                pins_next.wr_n = 1'b1;
                pins_next.out_n = 1'b1;
                doe_n_next = 1'b1;
                st_next = asp_pkg::ASP_IDLE;
            end
            default:
            begin
                pins_next.sel_n = 1'b1;
                pins_next.wr_n = 1'b1;
                pins_next.out_n = 1'b1;
                doe_n_next = 1'b1;
                wpend_next = 1'b0;
                st_next = asp_pkg::ASP_IDLE;
            end
        endcase
    end

    // ready is predicted one cycle ahead so it can come from a flop
    always_comb
    begin
        ready_next = (st_next == asp_pkg::ASP_IDLE) ||
            (st_reg == asp_pkg::ASP_RD && !expired && cnt == ONE_LEFT);
    end

    // ----------------------------------------
    // state and pin registers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            st_reg <= asp_pkg::ASP_IDLE;
        else
            st_reg <= st_next;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            pins_reg <= asp_pkg::PINS_RESET;
        else
            pins_reg <= pins_next;
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            dout_reg <= '0;
            doe_n_reg <= 1'b1;
        end
        else
        begin
            dout_reg <= dout_next;
            doe_n_reg <= doe_n_next;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            cur_reg <= '0;
            wpend_reg <= 1'b0;
        end
        else
        begin
            cur_reg <= cur_next;
            wpend_reg <= wpend_next;
        end
    end

    // ----------------------------------------
    // user side answers
    // ----------------------------------------
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ready_reg <= 1'b0;
        else
            ready_reg <= ready_next;
    end

    // sampled at the edge closing the access window
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_valid_reg <= 1'b0;
            rdata_reg <= '0;
        end
        else
        begin
            rsp_valid_reg <= (st_reg == asp_pkg::ASP_RD) && expired;
            if (st_reg == asp_pkg::ASP_RD && expired)
                rdata_reg <= mem_rdata;
        end
    end

    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wr_done_reg <= 1'b0;
            standby_reg <= 1'b1;
        end
        else
        begin
            wr_done_reg <= (st_reg == asp_pkg::ASP_HOLD);
            standby_reg <= pins_next.sel_n;
        end
    end

    assign req_ready = ready_reg;
    assign rsp_valid = rsp_valid_reg;
    assign rsp_rdata = rdata_reg;
    assign wr_done = wr_done_reg;
    assign standby = standby_reg;
    assign pins = pins_reg;
    assign mem_wdata = dout_reg;
    assign data_oe_n = doe_n_reg;

endmodule : asp_sram_host

// file: dv/asp_sram_host_sva.sv
`timescale 1ns/100ps

module asp_sram_host_sva (
    input wire logic clk, // system clock
    input wire logic resetn, // async reset, active low
    input wire logic rsp_valid, // read data pulse
    input wire logic standby, // memory deselected
    input wire asp_pkg::asp_pins_t pins, // address and strobes
    input wire logic [asp_pkg::DATA_W-1:0] mem_wdata, // data to memory
    input wire logic data_oe_n // data enable, low drives
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    // 10 ns clock: 70 ns access, 60 ns write overlap
    localparam int ACC_CYC = 7;
    localparam int OVL_CYC = 6;
    logic ovl;
    logic rd_act;
    logic [4:0] ovl_cnt_reg;
    logic [4:0] rd_cnt_reg;
    logic [asp_pkg::ADDR_W-1:0] addr_reg;
    assign ovl = !pins.sel_n && !pins.wr_n;
    assign rd_act = !pins.sel_n && pins.wr_n && !pins.out_n;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            ovl_cnt_reg <= 5'h00;
        else
            ovl_cnt_reg <= ovl ? ovl_cnt_reg + 5'h01 : 5'h00;
    end
    // a new address restarts the access wait, also within a chained read
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rd_cnt_reg <= 5'h00;
            addr_reg <= '0;
        end
        else
        begin
            rd_cnt_reg <= !rd_act ? 5'h00 : (pins.addr == addr_reg) ? rd_cnt_reg + 5'h01 : 5'h01;
            addr_reg <= pins.addr;
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    rd_strobe_a: assert property (!pins.sel_n && !pins.out_n |-> pins.wr_n && data_oe_n)
        else $error("read strobes with write strobe or host drive");
    wr_overlap_a: assert property (!pins.wr_n |-> !pins.sel_n)
        else $error("write strobe low outside select");
    wr_end_a: assert property ($rose(pins.wr_n) |-> $rose(pins.sel_n))
        else $error("write strobe and select did not rise together");
    wr_len_a: assert property ($fell(ovl) |-> ovl_cnt_reg >= OVL_CYC)
        else $error("write overlap too short");
    wr_data_a: assert property (ovl && $past(ovl) |-> !data_oe_n && $stable(mem_wdata)
        && $stable(pins.addr))
        else $error("data or address moved during write");
    wr_hold_a: assert property ($fell(ovl) |-> !data_oe_n && $stable(mem_wdata)
        && $stable(pins.addr))
        else $error("data or address not held at write end");
    bus_turn_a: assert property (!data_oe_n |-> pins.out_n)
        else $error("host drives data with output strobe low");
    rd_wait_a: assert property (rsp_valid |-> rd_cnt_reg >= ACC_CYC)
        else $error("read data taken before access time");
    standby_a: assert property (standby == pins.sel_n)
        else $error("standby does not follow select");
endmodule : asp_sram_host_sva

bind asp_sram_host asp_sram_host_sva asp_sram_host_sva_i (.clk(clk), .resetn(resetn),
    .rsp_valid(rsp_valid), .standby(standby), .pins(pins), .mem_wdata(mem_wdata),
    .data_oe_n(data_oe_n));

// file: dv/asp_sram_model.sv
`timescale 1ns/100ps

module asp_sram_model #(
    parameter int ACC_NS = 70, // address to data valid
    parameter int HOLD_NS = 10 // old data kept after address change
) (
    input wire asp_pkg::asp_pins_t pins, // address and strobes from host
    input wire logic [asp_pkg::DATA_W-1:0] dq_lines, // resolved data lines
    output logic [asp_pkg::DATA_W-1:0] dq_value, // device data value
    output logic dq_drive // device drives data lines
);
    logic [asp_pkg::DATA_W-1:0] mem [logic [asp_pkg::ADDR_W-1:0]];
    logic ovl;
    logic rd;
    realtime t_chg;
    assign ovl = !pins.sel_n && !pins.wr_n;
    assign rd = !pins.sel_n && pins.wr_n && !pins.out_n;
    initial
    begin
        dq_value = 8'h00;
        dq_drive = 1'b0;
        t_chg = 0;
    end
    always @(pins.addr or rd) t_chg = $realtime;
    // store at whichever strobe rises first
    always @(negedge ovl) mem[pins.addr] = dq_lines;
    // 1 ns allowance puts valid data ahead of the host's capturing clock edge
    always #1
    begin
        dq_drive = rd;
        if (!rd || ($realtime - t_chg >= HOLD_NS && $realtime - t_chg < ACC_NS - 1))
            dq_value = ~dq_value;
        else if ($realtime - t_chg >= ACC_NS - 1)
            dq_value = mem.exists(pins.addr) ? mem[pins.addr] : ~pins.addr[7:0];
    end
endmodule : asp_sram_model

// file: dv/asp_sram_host_test.sv
`timescale 1ns/100ps

module asp_sram_host_test;
    logic clk, resetn, req_valid, req_ready, rsp_valid, wr_done, standby, data_oe_n, dq_drive;
    logic [7:0] rsp_rdata, mem_wdata, mem_rdata, dq_value;
    asp_pkg::asp_req_t req;
    asp_pkg::asp_pins_t pins;
    int mismatches, checked;
    // cycles from take edge to the answer pulse at 10 ns
    localparam int RD_LAT = 7;
    localparam int WR_LAT = 8;
    // 25 ns float after a read before a queued write may start
    localparam int GAP_LAT = 3;

    asp_sram_host asp_sram_host_i (.clk(clk), .resetn(resetn), .req_valid(req_valid),
        .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .wr_done(wr_done), .standby(standby), .pins(pins), .mem_wdata(mem_wdata),
        .data_oe_n(data_oe_n), .mem_rdata(mem_rdata));
    asp_sram_model asp_sram_model_i (.pins(pins), .dq_lines(mem_rdata), .dq_value(dq_value),
        .dq_drive(dq_drive));
    assign mem_rdata = data_oe_n ? dq_value : mem_wdata;

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #10000;
        mismatches++;
        report_and_stop();
    end
    always @(negedge clk) if (resetn) cmp_bit(dq_drive && !data_oe_n, 1'b0);

    // ----------------------------------------
    // compare and drive tasks
    // ----------------------------------------
    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_bit
    task automatic cmp_data(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected data at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_data
    task automatic cmp_cnt(input int got, input int exp);
        checked++;
        if (got != exp)
        begin
            mismatches++;
            $display("unexpected cycles at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp_cnt
    // entered just after an edge; returns just after the take edge, valid still high
    task automatic issue(input logic w, input logic [18:0] a, input logic [7:0] d, output int n);
        req_valid = 1'b1;
        req = '{write: w, addr: a, wdata: d};
        n = 0;
        while (req_ready !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        n++;
    endtask : issue
    task automatic wait_rsp(input logic w, output int n);
        n = 0;
        while ((w ? wr_done : rsp_valid) !== 1'b1 && n < 50)
        begin
            @(posedge clk);
            #1;
            n++;
        end
    endtask : wait_rsp
    task automatic op(input logic w, input logic [18:0] a, input logic [7:0] d);
        int n;
        issue(w, a, d, n);
        req_valid = 1'b0;
        cmp_bit(standby, 1'b0);
        wait_rsp(w, n);
        cmp_cnt(n, w ? WR_LAT : RD_LAT);
        if (!w) cmp_data(rsp_rdata, d);
    endtask : op
    task automatic report_and_stop();
        if (mismatches == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset();
        cmp_bit(pins.sel_n, 1'b1);
        cmp_bit(pins.wr_n, 1'b1);
        cmp_bit(pins.out_n, 1'b1);
        cmp_bit(data_oe_n, 1'b1);
        cmp_bit(req_ready, 1'b0);
        cmp_bit(standby, 1'b1);
    endtask : t_reset
    task automatic t_boundary();
        op(1'b1, 19'h00000, 8'h5a);
        op(1'b1, 19'h7ffff, 8'ha5);
        op(1'b0, 19'h00000, 8'h5a);
        op(1'b0, 19'h7ffff, 8'ha5);
    endtask : t_boundary
    task automatic t_overwrite();
        op(1'b1, 19'h12345, 8'h3c);
        op(1'b1, 19'h12345, 8'hc3);
        op(1'b0, 19'h12345, 8'hc3);
    endtask : t_overwrite
    task automatic t_chain();
        int n;
        op(1'b1, 19'h00100, 8'h11);
        op(1'b1, 19'h00101, 8'h22);
        issue(1'b0, 19'h00100, 8'h00, n);
        issue(1'b0, 19'h00101, 8'h00, n);
        req_valid = 1'b0;
        cmp_cnt(n, RD_LAT);
        cmp_bit(pins.sel_n, 1'b0);
        wait_rsp(1'b0, n);
        cmp_cnt(n, 0);
        cmp_data(rsp_rdata, 8'h11);
        @(posedge clk);
        #1;
        wait_rsp(1'b0, n);
        cmp_cnt(n, RD_LAT - 1);
        cmp_data(rsp_rdata, 8'h22);
    endtask : t_chain
    // a write offered during a read waits for the bus to float first
    task automatic t_turn();
        int n;
        issue(1'b0, 19'h00101, 8'h00, n);
        issue(1'b1, 19'h00101, 8'h77, n);
        req_valid = 1'b0;
        cmp_cnt(n, RD_LAT);
        cmp_data(rsp_rdata, 8'h22);
        wait_rsp(1'b1, n);
        cmp_cnt(n, GAP_LAT + WR_LAT);
        op(1'b0, 19'h00101, 8'h77);
    endtask : t_turn

    initial
    begin
        mismatches = 0;
        checked = 0;
        resetn = 1'b0;
        req_valid = 1'b0;
        req = '0;
        repeat (3) @(posedge clk);
        #1;
        t_reset();
        repeat (2) @(posedge clk);
        #1;
        resetn = 1'b1;
        @(posedge clk);
        #1;
        t_boundary();
        t_overwrite();
        t_chain();
        t_turn();
        report_and_stop();
    end
endmodule : asp_sram_host_test
